/* File: core/pdmin_port.v */
// Notes on behaviour
// - data pin is double rate: one channel per clock edge, two channels interleaved
// - clock pin is input when direction is 0 (default), output when 1
// - capture edge select 0 samples on rising edge (default), 1 on falling
// - output mode with gate 0 holds clock pin low; gate 1 runs it at rates 00 and 01, reserved rates hold it low
// - sample clock source 0 ties sampling clock to ground; 1 uses clock pin
// - rate 00 gives 64/32/16 times sample rate, 01 gives 128/64/32; rest reserved
// - output clock has 50% duty at the rate chosen
// - role map 0 feeds sensor path (default), 1 feeds playback path
// - sensor data decimated, aligned to sense samples, sent to serial audio out
// - single, double, quadruple speed mean 44.1/48, 88.2/96, 176.4/192 kHz
`include "pdmin_consts.vh"
`default_nettype none

module pdmin_port #(
  parameter CNT_W  = `PDMIN_CNT_W,
  parameter WORD_W = `PDMIN_WORD_W,
  parameter HALF_N = `PDMIN_GEN_HALF_NS / `PDMIN_SYS_PERIOD_NS
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              oversample_clock_pin_i,
  output reg               oversample_clock_pin_o_q,
  output reg               oversample_clock_pin_oe_q,
  input  wire              oversample_data_pin,
  input  wire              capture_edge_sel,
  input  wire              clock_direction_sel,
  input  wire              master_clock_gate,
  input  wire              sample_clock_source,
  input  wire [1:0]        oversampling_rate_sel,
  input  wire              input_role_map,
  input  wire [1:0]        sample_speed_sel,
  input  wire              sense_sample_tick,
  output reg  [1:0]        play_bits_q,
  output reg               play_valid_q,
  output wire [WORD_W-1:0] serial_audio_out_data_q,
  output wire              serial_audio_out_valid_q,
  input  wire              serial_audio_out_ready,
  output reg  [CNT_W-1:0]  ratio_q
);

  localparam [7:0] HALF_CNT = HALF_N[7:0];

  ////////////////////////////////////////////////////////////////////////
  // reset release

  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_i_n = rst_s2_q;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control fields

  reg       edge_q;
  reg       dir_q;
  reg       gate_q;
  reg       src_q;
  reg [1:0] rate_q;
  reg       map_q;

  always @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      edge_q <= `PDMIN_EDGE_RST;
      dir_q  <= `PDMIN_DIR_RST;
      gate_q <= `PDMIN_GATE_RST;
      src_q  <= `PDMIN_SRC_RST;
      rate_q <= `PDMIN_RATE_RST;
      map_q  <= `PDMIN_MAP_RST;
    end
    else
    begin
      edge_q <= capture_edge_sel;
      dir_q  <= clock_direction_sel;
      gate_q <= master_clock_gate;
      src_q  <= sample_clock_source;
      rate_q <= oversampling_rate_sel;
      map_q  <= input_role_map;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock generator

  reg [7:0] div_q;
  reg       gen_clk_q;
  wire [7:0] half_len = (rate_q == `PDMIN_RATE_HIGH) ? (HALF_CNT >> 1) : HALF_CNT;
  wire       gen_run = dir_q & gate_q & (rate_q[1] == 1'b0);

  always @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      div_q                     <= 8'h00;
      gen_clk_q                 <= 1'b0;
      oversample_clock_pin_o_q  <= 1'b0;
      oversample_clock_pin_oe_q <= 1'b0;
    end
    else
    begin
      oversample_clock_pin_oe_q <= dir_q;
      if (!gen_run)
      begin
        div_q     <= 8'h00;
        gen_clk_q <= 1'b0;
      end
      else if (div_q >= half_len - 8'h01)
      begin
        div_q     <= 8'h00;
        gen_clk_q <= ~gen_clk_q;
      end
      else
      begin
        div_q <= div_q + 8'h01;
      end
      oversample_clock_pin_o_q <= gen_clk_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg ck_s1_q;
  reg ck_s2_q;
  reg dt_s1_q;
  reg dt_s2_q;

  always @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
    end
    else
    begin
      ck_s1_q <= oversample_clock_pin_i;
      ck_s2_q <= ck_s1_q;
      dt_s1_q <= oversample_data_pin;
      dt_s2_q <= dt_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge finding on the selected sample clock
  // output mode samples the pin readback of the generated clock

  reg  ck_s3_q;
  wire smp_src = src_q & ck_s2_q;

  always @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      ck_s3_q <= 1'b0;
    end
    else
    begin
      ck_s3_q <= smp_src;
    end
  end

  wire rise = smp_src & ~ck_s3_q;
  wire fall = ~smp_src & ck_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // double rate capture

  reg  [1:0] pair_q;
  wire       first_edge  = edge_q ? fall : rise;
  wire       second_edge = edge_q ? rise : fall;

  always @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      pair_q       <= 2'h0;
      play_bits_q  <= 2'h0;
      play_valid_q <= 1'b0;
    end
    else
    begin
      play_valid_q <= 1'b0;
      if (first_edge)
      begin
        pair_q[0] <= dt_s2_q;
      end
      if (second_edge)
      begin
        pair_q[1] <= dt_s2_q;
        if (map_q)
        begin
          play_bits_q  <= {dt_s2_q, pair_q[0]};
          play_valid_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sensor decimation

  reg  [WORD_W-1:0]  word_q;
  reg                word_vld_q;
  wire               buf_ready;
  wire [CNT_W-1:0]   base_ratio = (rate_q == `PDMIN_RATE_HIGH) ?
                                  `PDMIN_RATIO_HIGH : `PDMIN_RATIO_LOW;
  wire               sensor_on = ~map_q;
  wire [1:0]         cap = {sensor_on & second_edge, sensor_on & first_edge};
  wire [CNT_W-1:0]   bit_in = {{(CNT_W-1){1'b0}}, dt_s2_q};
  wire [2*CNT_W-1:0] acc_all;

  // one ones-counter per channel, saturating at the ratio
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_acc
      reg [CNT_W-1:0] acc_q;

      always @(posedge clk or negedge rst_i_n)
      begin
        if (!rst_i_n)
        begin
          acc_q <= {CNT_W{1'b0}};
        end
        else if (sense_sample_tick)
        begin
          acc_q <= cap[ch] ? bit_in : {CNT_W{1'b0}};
        end
        else if (cap[ch] && (acc_q != ratio_q))
        begin
          acc_q <= acc_q + bit_in;
        end
      end

      assign acc_all[ch*CNT_W +: CNT_W] = acc_q;
    end
  endgenerate

  always @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      ratio_q    <= `PDMIN_RATIO_LOW;
      word_q     <= {WORD_W{1'b0}};
      word_vld_q <= 1'b0;
    end
    else
    begin
      case (sample_speed_sel)
        `PDMIN_SPEED_DOUBLE: ratio_q <= base_ratio >> 1;
        `PDMIN_SPEED_QUAD:   ratio_q <= base_ratio >> 2;
        default:             ratio_q <= base_ratio;
      endcase
      if (word_vld_q && buf_ready)
      begin
        word_vld_q <= 1'b0;
      end
      if (sense_sample_tick)
      begin
        word_q     <= acc_all;
        word_vld_q <= sensor_on;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output buffer

  pdmin_buf #(
    .WIDTH (WORD_W),
    .DEPTH (2)
  ) u_buf (
    .clk         (clk),
    .rst_n       (rst_i_n),
    .in_data     (word_q),
    .in_valid    (word_vld_q),
    .in_ready    (buf_ready),
    .out_data_q  (serial_audio_out_data_q),
    .out_valid_q (serial_audio_out_valid_q),
    .out_ready   (serial_audio_out_ready)
  );

endmodule

`default_nettype wire

/* File: core/pdmin_consts.vh */
`ifndef PDMIN_CONSTS_VH
`define PDMIN_CONSTS_VH

// control defaults after reset
`define PDMIN_EDGE_RST      1'b0
`define PDMIN_DIR_RST       1'b0
`define PDMIN_GATE_RST      1'b0
`define PDMIN_SRC_RST       1'b1
`define PDMIN_RATE_RST      2'h0
`define PDMIN_MAP_RST       1'b0

// oversampling rate codes
`define PDMIN_RATE_LOW      2'h0
`define PDMIN_RATE_HIGH     2'h1

// ratio to single speed sample rate
`define PDMIN_RATIO_LOW     8'h40
`define PDMIN_RATIO_HIGH    8'h80

// speed codes: single, double, quadruple
`define PDMIN_SPEED_SINGLE  2'h0
`define PDMIN_SPEED_DOUBLE  2'h1
`define PDMIN_SPEED_QUAD    2'h2

// timing of the generated clock
`define PDMIN_SYS_PERIOD_NS 100
`define PDMIN_GEN_HALF_NS   400

// decimated word layout
`define PDMIN_CNT_W         8
`define PDMIN_WORD_W        16

`endif

/* File: core/pdmin_buf.v */
`default_nettype none

module pdmin_buf #(
  parameter WIDTH = 16,
  parameter DEPTH = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data_q,
  output reg              out_valid_q,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg             wr_ptr_q;
  reg             rd_ptr_q;
  reg [1:0]       count_q;
  wire            push;
  wire            pop;
  wire            load;

  ////////////////////////////////////////////////////////////////////////
  // storage

  assign in_ready = (count_q != 2'h2);
  assign push     = in_valid & in_ready;
  assign load     = (count_q != 2'h0) & (~out_valid_q | out_ready);
  assign pop      = load;

  always @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q    <= 1'b0;
      rd_ptr_q    <= 1'b0;
      count_q     <= 2'h0;
      out_data_q  <= {WIDTH{1'b0}};
      out_valid_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
      begin
        rd_ptr_q   <= ~rd_ptr_q;
        out_data_q <= mem_q[rd_ptr_q];
      end
      if (load)
      begin
        out_valid_q <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid_q <= 1'b0;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

/* File: verif/pdmin_mic.sv */
`default_nettype none
module pdmin_mic (
  input  wire logic run,
  input  wire logic oe,
  input  wire logic dev_ck,
  input  wire logic b0,
  input  wire logic b1,
  output wire logic ck,
  output wire logic dat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic own = 1'b0;
  logic tog = 1'b0;
  logic bit_q = 1'b0;
  // own clock runs only within frames
  always #400 own = run ? !own : 1'b0;
  assign ck = oe ? dev_ck : own;
  // released line changes every cycle
  always #100 if (!run && !oe) tog = !tog;
  // next bit set 250 ns after each clock edge
  always @(ck) #250 bit_q = ck ? b1 : b0;
  assign dat = (run || oe) ? bit_q : tog;
endmodule
`default_nettype wire

/* File: verif/pdmin_monitor.sv */
`default_nettype none
module pdmin_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       oversample_clock_pin_o_q,
  input wire logic       oversample_clock_pin_oe_q,
  input wire logic       clock_direction_sel,
  input wire logic       master_clock_gate,
  input wire logic       sample_clock_source,
  input wire logic [1:0] oversampling_rate_sel,
  input wire logic       input_role_map,
  input wire logic       sense_sample_tick,
  input wire logic       play_valid_q,
  input wire logic       serial_audio_out_valid_q,
  input wire logic       serial_audio_out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic ck_o  = oversample_clock_pin_o_q;
  wire logic ck_oe = oversample_clock_pin_oe_q;
  wire logic sv    = serial_audio_out_valid_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rsvd;
    clock_direction_sel && master_clock_gate && oversampling_rate_sel[1];
  endsequence
  sequence s_stall;
    sv && !serial_audio_out_ready;
  endsequence
  a_oe_output: assert property (clock_direction_sel [*4] |=> ck_oe)
    else $error("clock pin not driven");
  a_idle_low: assert property (!ck_oe [*2] |-> !ck_o)
    else $error("clock pin high while not driven");
  a_gate_low: assert property (!master_clock_gate [*3] |=> !ck_o)
    else $error("gated clock pin not low");
  a_rsvd_stop: assert property (s_rsvd [*4] |=> $stable(ck_o))
    else $error("clock runs at reserved rate");
  a_map_sensor: assert property (!input_role_map [*4] |=> !play_valid_q)
    else $error("playback on sensor map");
  a_src_ground: assert property (!sample_clock_source [*6] |=> !play_valid_q)
    else $error("capture with grounded source");
  a_word_hold: assert property (s_stall |=> sv)
    else $error("word lost in stall");
  a_tick_word: assert property (sense_sample_tick && !sv && !input_role_map |-> ##[1:4] sv)
    else $error("no word after tick");
endmodule
bind pdmin_port pdmin_monitor mon (
  .clk, .rst_n, .oversample_clock_pin_o_q, .oversample_clock_pin_oe_q, .clock_direction_sel,
  .master_clock_gate, .sample_clock_source, .oversampling_rate_sel, .input_role_map,
  .sense_sample_tick, .play_valid_q, .serial_audio_out_valid_q, .serial_audio_out_ready
);
`default_nettype wire

/* File: verif/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, b0 = 1'b1, b1 = 1'b0;
  logic capture_edge_sel = 1'b0, clock_direction_sel = 1'b0, master_clock_gate = 1'b0;
  logic sample_clock_source = 1'b1, input_role_map = 1'b0, sense_sample_tick = 1'b0;
  logic serial_audio_out_ready = 1'b1;
  logic [1:0] oversampling_rate_sel = 2'h0, sample_speed_sel = 2'h0;
  wire logic oversample_clock_pin_i, oversample_data_pin, play_valid_q;
  wire logic oversample_clock_pin_o_q, oversample_clock_pin_oe_q, serial_audio_out_valid_q;
  wire logic [1:0] play_bits_q;
  wire logic [15:0] serial_audio_out_data_q;
  wire logic [7:0] ratio_q;
  int mismatches = 0, compares = 0;
  pdmin_port #(.HALF_N(4)) uut (.*);
  pdmin_mic mic (.run, .oe(oversample_clock_pin_oe_q), .dev_ck(oversample_clock_pin_o_q),
    .b0, .b1, .ck(oversample_clock_pin_i), .dat(oversample_data_pin));
  initial forever #50 clk = !clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic w_play;
    step(1);
    for (int i = 0; i < 99 && play_valid_q !== 1'b1; i++)
      step(1);
    chk("pulse", play_valid_q, 1'b1);
  endtask
  task automatic no_play;
    int c = 0;
    step(8);
    repeat (40)
    begin
      step(1);
      c += play_valid_q;
    end
    chk("pairs", c, 0);
  endtask
  task automatic tick;
    sense_sample_tick = 1'b1;
    step(1);
    sense_sample_tick = 1'b0;
  endtask
  task automatic meas(input int eh, er);
    int h = 0, r = 0;
    logic p;
    step(6);
    p = oversample_clock_pin_o_q;
    repeat (80)
    begin
      step(1);
      h += oversample_clock_pin_o_q;
      r += oversample_clock_pin_o_q & !p;
      p = oversample_clock_pin_o_q;
    end
    chk("high", h, eh);
    chk("rises", r, er);
  endtask
  task automatic t_ratio;
    chk("oe", oversample_clock_pin_oe_q, 1'b0);
    for (int r = 0; r < 2; r++)
      for (int s = 0; s < 4; s++)
      begin
        oversampling_rate_sel = 2'(r);
        sample_speed_sel = 2'(s);
        step(4);
        chk("ratio", ratio_q, (8'h40 << r) >> (s % 3));
      end
    oversampling_rate_sel = 2'h0;
    sample_speed_sel = 2'h0;
    $display("done ratio");
  endtask
  task automatic t_play;
    input_role_map = 1'b1;
    run = 1'b1;
    step(16);
    w_play;
    chk("bits", play_bits_q, 2'h1);
    capture_edge_sel = 1'b1;
    step(16);
    w_play;
    chk("bits", play_bits_q, 2'h2);
    capture_edge_sel = 1'b0;
    sample_clock_source = 1'b0;
    no_play;
    sample_clock_source = 1'b1;
    input_role_map = 1'b0;
    no_play;
    $display("done play");
  endtask
  task automatic t_sensor;
    int c = 0;
    tick;
    step(511);
    serial_audio_out_ready = 1'b0;
    tick;
    step(5);
    chk("word", serial_audio_out_data_q, 16'h0040);
    repeat (3)
    begin
      step(5);
      tick;
    end
    step(5);
    chk("held", serial_audio_out_data_q, 16'h0040);
    serial_audio_out_ready = 1'b1;
    repeat (20)
    begin
      c += serial_audio_out_valid_q;
      step(1);
    end
    chk("words", c, 4);
    $display("done sensor");
  endtask
  task automatic t_out;
    run = 1'b0;
    clock_direction_sel = 1'b1;
    meas(0, 0);
    chk("oe", oversample_clock_pin_oe_q, 1'b1);
    chk("pin", oversample_clock_pin_o_q, 1'b0);
    master_clock_gate = 1'b1;
    meas(40, 10);
    oversampling_rate_sel = 2'h1;
    meas(40, 20);
    oversampling_rate_sel = 2'h2;
    meas(0, 0);
    clock_direction_sel = 1'b0;
    step(4);
    chk("oe", oversample_clock_pin_oe_q, 1'b0);
    $display("done out");
  endtask
  initial
  begin
    step(10);
    rst_n = 1'b1;
    step(4);
    t_ratio;
    t_play;
    t_sensor;
    t_out;
    end_of_test;
  end
  initial
  begin
    #1000000;
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
